// file: hdl/bus_strap_config_latch.sv
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "bus_strap_cfg.svh"

module bus_strap_config_latch (
  input wire logic clk,
  input wire logic srst,
  input wire logic host_bus_clock,
  input wire logic cfg_cycle,
  input wire logic bus_low_voltage,
  input wire logic [13:0] gpio_in,
  output logic [13:0] gpio_out,
  output logic [13:0] gpio_oe,
  output logic bus_drive_en,
  output bus_strap_pkg::strap_cfg_s cfg,
  output logic config_valid,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o
);

  // pins from outside the clock domain
  logic [13:0] gpio_meta;
  logic [13:0] gpio_sync;
  logic lowv_meta;
  logic lowv_sync;
  logic [13:0] strap_latched;
  bus_strap_pkg::commit_state_e state;
  bus_strap_pkg::commit_state_e next_state;
  logic cfg_pulse;
  logic [13:0] gpio_out_reg;
  logic [13:0] gpio_oe_reg;
  logic access;
  logic [31:0] read_word;
  logic wr_commit;

  // link domain
  logic link_rst_meta;
  logic link_rst;
  logic iso_meta;
  logic iso_sync;
  logic req_toggle;
  logic req_sent;
  logic bus_drive_reg;

  // clk-side crossing of the config-cycle event
  logic tog_meta;
  logic tog_sync;
  logic tog_prev;

  function automatic bus_strap_pkg::strap_cfg_s decode_straps(
    input logic [13:0] s,
    input logic low_v
  );
    bus_strap_pkg::strap_cfg_s c;
    logic [2:0] bc;
    logic [2:0] rc;
    c = '0;
    bc = s[`STRAP_BUS_HI:`STRAP_BUS_LO];
    rc = s[`STRAP_ROM_HI:`STRAP_ROM_LO];
    c.vga_enable = ~s[`STRAP_VGA_OFF];
    c.bus_isolate = s[`STRAP_ISOLATE];
    c.devsel_ad17 = bc[0];
    case (bc[2:1])
      2'b00, 2'b01: begin
        c.use_pll = 1'b1;
        // supply level decides 4X versus 1X/2X for codes 0x0 and 0x1
        c.bus_mode = (!bc[1] && low_v) ? bus_strap_pkg::mode_agp4x
                                       : bus_strap_pkg::mode_agp1x2x;
      end
      2'b10: begin
        // line 4 means PLL bypass here, not device select
        c.devsel_ad17 = 1'b0;
        c.use_pll = ~bc[0];
        c.bus_mode = bc[0] ? bus_strap_pkg::mode_pci33
                           : bus_strap_pkg::mode_pci66;
      end
      default: begin
        c.use_pll = 1'b0;
        c.bus_mode = bus_strap_pkg::mode_agp1x;
      end
    endcase
    c.bus_clock_skew_field = s[`STRAP_SKEW_HI:`STRAP_SKEW_LO];
    c.single_double_clock_skew_field = s[`STRAP_DD_HI:`STRAP_DD_LO];
    case (rc)
      3'h0, 3'h1: begin
        c.rom_kind = bus_strap_pkg::rom_none;
        c.chip_identity_select = rc[0];
        c.identity_from_rom = 1'b0;
      end
      3'h2, 3'h3: begin
        c.rom_kind = bus_strap_pkg::rom_reserved;
        c.identity_from_rom = 1'b0;
      end
      3'h4: begin
        c.rom_kind = bus_strap_pkg::rom_parallel;
        c.identity_from_rom = 1'b1;
      end
      3'h5: begin
        c.rom_kind = bus_strap_pkg::rom_serial_a;
        c.identity_from_rom = 1'b1;
      end
      3'h6: begin
        c.rom_kind = bus_strap_pkg::rom_serial_b;
        c.identity_from_rom = 1'b1;
      end
      default: begin
        c.rom_kind = bus_strap_pkg::rom_serial_c;
        c.identity_from_rom = 1'b1;
      end
    endcase
    return c;
  endfunction : decode_straps

  // pull-downs sit in the pad; here an open line simply arrives as 0
  always_ff @(posedge clk) begin
    gpio_meta <= gpio_in;
    gpio_sync <= gpio_meta;
    lowv_meta <= bus_low_voltage;
    lowv_sync <= lowv_meta;
  end

  // capture only while reset is held, so a released chip never resamples
  always_ff @(posedge clk) begin
    if (srst) begin
      strap_latched <= gpio_sync;
    end
  end

  // commit sequencing
  always_comb begin
    next_state = state;
    case (state)
      bus_strap_pkg::st_capture: next_state = bus_strap_pkg::st_wait_cfg;
      bus_strap_pkg::st_wait_cfg: begin
        if (cfg_pulse) begin
          next_state = bus_strap_pkg::st_done;
        end
      end
      bus_strap_pkg::st_done: next_state = bus_strap_pkg::st_done;
      default: next_state = bus_strap_pkg::st_capture;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= bus_strap_pkg::st_capture;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg <= '0;
    end else if (state == bus_strap_pkg::st_wait_cfg && cfg_pulse) begin
      cfg <= decode_straps(strap_latched, lowv_sync);
    end
  end

  assign config_valid = (state == bus_strap_pkg::st_done);

  // link side: reset and isolate level come in through two flops each
  always_ff @(posedge host_bus_clock) begin
    link_rst_meta <= srst;
    link_rst <= link_rst_meta;
    iso_meta <= strap_latched[`STRAP_ISOLATE];
    iso_sync <= iso_meta;
  end

  // one toggle per reset; later config cycles carry nothing
  always_ff @(posedge host_bus_clock) begin
    if (link_rst) begin
      req_toggle <= 1'b0;
      req_sent <= 1'b0;
    end else if (cfg_cycle && !req_sent) begin
      req_toggle <= ~req_toggle;
      req_sent <= 1'b1;
    end
  end

  // bus pins float in reset; an isolated device never drives the bus
  always_ff @(posedge host_bus_clock) begin
    if (link_rst) begin
      bus_drive_reg <= 1'b0;
    end else begin
      bus_drive_reg <= ~iso_sync;
    end
  end

  // link reset lags by a few link edges, so reset itself gates the enable
  assign bus_drive_en = bus_drive_reg & ~srst;

  always_ff @(posedge clk) begin
    if (srst) begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_prev <= 1'b0;
    end else begin
      tog_meta <= req_toggle;
      tog_sync <= tog_meta;
      tog_prev <= tog_sync;
    end
  end

  assign cfg_pulse = tog_sync ^ tog_prev;

  // wishbone slave, answer one cycle after the request
  assign access = cyc_i && stb_i && !ack_o;
  // writes land on the edge that samples ack high, while the master still holds
  assign wr_commit = cyc_i && stb_i && we_i && ack_o;

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= access;
    end
  end

  always_comb begin
    case (adr_i)
      `REG_STRAP_RAW: read_word = {18'h00000, strap_latched};
      `REG_CONFIG_STATUS: read_word = {15'h0000, cfg, config_valid};
      `REG_GPIO_OUT: read_word = {18'h00000, gpio_out_reg};
      `REG_GPIO_OE: read_word = {18'h00000, gpio_oe_reg};
      `REG_GPIO_LEVEL: read_word = {18'h00000, gpio_sync};
      default: read_word = `UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dat_o <= 32'h0000_0000;
    end else if (access && !we_i) begin
      dat_o <= read_word;
    end
  end

  // per-lane writes; lane 1 carries only six live bits
  generate
    for (genvar lane = 0; lane < 2; lane++) begin : g_lane
      localparam int LO = lane * 8;
      localparam int HI = (lane == 0) ? 7 : 13;
      localparam logic [13:0] OUT_RST = `GPIO_OUT_RESET;
      localparam logic [13:0] OE_RST = `GPIO_OE_RESET;
      always_ff @(posedge clk) begin
        if (srst) begin
          gpio_out_reg[HI:LO] <= OUT_RST[HI:LO];
          gpio_oe_reg[HI:LO] <= OE_RST[HI:LO];
        end else if (wr_commit && sel_i[lane]) begin
          if (adr_i == `REG_GPIO_OUT) begin
            gpio_out_reg[HI:LO] <= dat_i[HI:LO];
          end
          if (adr_i == `REG_GPIO_OE) begin
            gpio_oe_reg[HI:LO] <= dat_i[HI:LO];
          end
        end
      end
    end
  endgenerate

  assign gpio_out = gpio_out_reg;
  // gating keeps pins floating even if a future reset value changes
  assign gpio_oe = srst ? 14'h0000 : gpio_oe_reg;

  // checks
  a_pins_float_reset: assert property (@(posedge clk)
    srst |-> gpio_oe == 14'h0000)
    else $error("gpio driven during reset");

  a_bus_float_reset: assert property (@(posedge host_bus_clock)
    disable iff (1'b0) link_rst |=> !bus_drive_en)
    else $error("bus driven during reset");

  a_strap_capture: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> strap_latched == $past(gpio_sync))
    else $error("straps not captured at reset release");

  a_straps_hold: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) |-> $stable(strap_latched) ##1 $stable(strap_latched))
    else $error("straps resampled after reset");

  a_commit_timing: assert property (@(posedge clk) disable iff (srst)
    (!config_valid && !cfg_pulse) |=> !config_valid)
    else $error("commit without config cycle");

  a_commit_event: assert property (@(posedge clk) disable iff (srst)
    (state == bus_strap_pkg::st_wait_cfg && cfg_pulse)
      |=> config_valid && cfg.vga_enable == !strap_latched[`STRAP_VGA_OFF]
          && cfg.bus_isolate == strap_latched[`STRAP_ISOLATE])
    else $error("config cycle did not commit straps");

  a_isolate_quiet: assert property (@(posedge host_bus_clock)
    disable iff (link_rst) iso_sync |=> !bus_drive_en)
    else $error("isolated device drives bus");

  a_pci_decode: assert property (@(posedge clk) disable iff (srst)
    (config_valid && strap_latched[6:5] == 2'b10)
      |-> cfg.use_pll == !strap_latched[4] && !cfg.devsel_ad17
          && (cfg.bus_mode == bus_strap_pkg::mode_pci66) == !strap_latched[4])
    else $error("pci code decoded wrongly");

  a_agp_ref_decode: assert property (@(posedge clk) disable iff (srst)
    (config_valid && strap_latched[6:5] == 2'b11)
      |-> !cfg.use_pll && cfg.bus_mode == bus_strap_pkg::mode_agp1x
          && cfg.devsel_ad17 == strap_latched[4])
    else $error("reference-clock agp decoded wrongly");

  a_skew_fields: assert property (@(posedge clk) disable iff (srst)
    config_valid |-> cfg.bus_clock_skew_field == strap_latched[1:0]
      && cfg.single_double_clock_skew_field == strap_latched[3:2])
    else $error("skew fields wrong");

  a_rom_identity: assert property (@(posedge clk) disable iff (srst)
    (config_valid && strap_latched[13:12] == 2'b00)
      |-> cfg.rom_kind == bus_strap_pkg::rom_none && !cfg.identity_from_rom
          && cfg.chip_identity_select == strap_latched[11])
    else $error("no-rom identity wrong");

  a_wb_ack_pulse: assert property (@(posedge clk) disable iff (srst)
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
    else $error("ack not a single pulse");

  a_bus_gate_reset: assert property (@(posedge clk)
    srst |-> !bus_drive_en)
    else $error("bus enable high during reset");

  a_vga_isolate_decode: assert property (@(posedge clk) disable iff (srst)
    config_valid |-> cfg.vga_enable == !strap_latched[`STRAP_VGA_OFF]
      && cfg.bus_isolate == strap_latched[`STRAP_ISOLATE])
    else $error("vga or isolate strap decoded wrongly");

  a_agp_pll_decode: assert property (@(posedge clk) disable iff (srst)
    (config_valid && !strap_latched[6])
      |-> cfg.use_pll && cfg.devsel_ad17 == strap_latched[4]
          && (cfg.bus_mode == bus_strap_pkg::mode_agp1x2x
              || (!strap_latched[5] && cfg.bus_mode == bus_strap_pkg::mode_agp4x)))
    else $error("pll agp code decoded wrongly");

  a_rom_kind_decode: assert property (@(posedge clk) disable iff (srst)
    (config_valid && strap_latched[13])
      |-> cfg.identity_from_rom
          && cfg.rom_kind == bus_strap_pkg::rom_kind_e'(strap_latched[13:11]))
    else $error("rom kind decoded wrongly");

  a_single_commit: assert property (@(posedge host_bus_clock) disable iff (link_rst)
    req_sent |=> $stable(req_toggle) && req_sent)
    else $error("second config cycle forwarded");

  c_commit: cover property (@(posedge clk) disable iff (srst)
    $rose(config_valid));

  c_pci_commit: cover property (@(posedge clk) disable iff (srst)
    $rose(config_valid) && cfg.bus_mode == bus_strap_pkg::mode_pci33);

  c_isolated: cover property (@(posedge host_bus_clock) disable iff (link_rst)
    iso_sync && !bus_drive_en);

  c_agp4x_commit: cover property (@(posedge clk) disable iff (srst)
    $rose(config_valid) && cfg.bus_mode == bus_strap_pkg::mode_agp4x);

  c_rom_identity: cover property (@(posedge clk) disable iff (srst)
    config_valid && cfg.identity_from_rom);

endmodule : bus_strap_config_latch
`default_nettype wire

// file: hdl/bus_strap_cfg.svh
`ifndef BUS_STRAP_CFG_SVH
`define BUS_STRAP_CFG_SVH

// strap pin positions on the general-purpose lines
`define STRAP_W 14
`define STRAP_SKEW_LO 0
`define STRAP_SKEW_HI 1
`define STRAP_DD_LO 2
`define STRAP_DD_HI 3
`define STRAP_BUS_LO 4
`define STRAP_BUS_HI 6
`define STRAP_VGA_OFF 7
`define STRAP_ISOLATE 8
`define STRAP_ROM_LO 11
`define STRAP_ROM_HI 13

// register byte offsets, 32-bit aligned words
`define REG_STRAP_RAW 8'h00
`define REG_CONFIG_STATUS 8'h04
`define REG_GPIO_OUT 8'h08
`define REG_GPIO_OE 8'h0c
`define REG_GPIO_LEVEL 8'h10

// status word layout
`define STATUS_VALID_BIT 0
`define STATUS_CFG_LO 1
`define STATUS_CFG_HI 16

// reset values
`define GPIO_OUT_RESET 14'h0000
`define GPIO_OE_RESET 14'h0000
`define UNMAPPED_READ 32'h0000_0000

`endif

// file: hdl/bus_strap_pkg.sv
`default_nettype none

package bus_strap_pkg;

  typedef enum logic [2:0] {
    st_capture = 3'b001,
    st_wait_cfg = 3'b010,
    st_done = 3'b100
  } commit_state_e;

  typedef enum logic [2:0] {
    mode_agp4x = 3'h0,
    mode_agp1x2x = 3'h1,
    mode_agp1x = 3'h2,
    mode_pci66 = 3'h3,
    mode_pci33 = 3'h4
  } bus_mode_e;

  typedef enum logic [2:0] {
    rom_none = 3'h0,
    rom_reserved = 3'h2,
    rom_parallel = 3'h4,
    rom_serial_a = 3'h5,
    rom_serial_b = 3'h6,
    rom_serial_c = 3'h7
  } rom_kind_e;

  // vga_enable is bit 0, identity_from_rom bit 15
  typedef struct packed {
    logic identity_from_rom;
    logic chip_identity_select;
    rom_kind_e rom_kind;
    logic [1:0] single_double_clock_skew_field;
    logic [1:0] bus_clock_skew_field;
    logic devsel_ad17;
    logic use_pll;
    bus_mode_e bus_mode;
    logic bus_isolate;
    logic vga_enable;
  } strap_cfg_s;

endpackage : bus_strap_pkg

`default_nettype wire

// file: verif/host_chipset_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_chipset_model (
  input wire logic cfg_req,
  output logic host_bus_clock,
  output logic cfg_cycle
);
  logic seen;

  // bus clock runs free: it times every bus transaction, not only config ones
  initial begin
    host_bus_clock = 1'b0;
    #1.7;
    forever #6 host_bus_clock = ~host_bus_clock;
  end

  // a toggle request lets the bench ask from its own clock without a pulse race
  initial begin
    seen = 1'b0;
    cfg_cycle = 1'b0;
    forever begin
      @(posedge host_bus_clock);
      cfg_cycle <= (cfg_req != seen);
      seen <= cfg_req;
    end
  end
endmodule : host_chipset_model

`default_nettype wire

// file: verif/bus_strap_config_latch_test.sv
`timescale 1ns/1ps
`default_nettype none

module bus_strap_config_latch_test;
  logic clk, srst, cfg_req, lowv, cyc, stb, we;
  logic [13:0] gpio_in, g;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, r;
  wire logic hbc, cfg_cycle, bus_drive_en, config_valid, ack_o;
  wire logic [13:0] gpio_out, gpio_oe;
  wire logic [31:0] dat_o;
  wire bus_strap_pkg::strap_cfg_s cfg;
  bus_strap_pkg::strap_cfg_s e;
  int fail_count = 0;
  int total_checks = 0;

  host_chipset_model host_chipset_model_i (.cfg_req(cfg_req), .host_bus_clock(hbc),
    .cfg_cycle(cfg_cycle));

  bus_strap_config_latch bus_strap_config_latch_i (.clk(clk), .srst(srst),
    .host_bus_clock(hbc), .cfg_cycle(cfg_cycle), .bus_low_voltage(lowv), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .bus_drive_en(bus_drive_en), .cfg(cfg),
    .config_valid(config_valid), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : check

  // called just after a rising edge; holds the request until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] rd);
    int n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      fail_count++;
      give_verdict();
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] v;
    wb(1'b0, a, 32'h0, 4'hf, v);
    check(v, exp, msg);
  endtask : rd_chk

  function automatic bus_strap_pkg::strap_cfg_s exp_cfg(input logic [13:0] s, input logic lv);
    bus_strap_pkg::strap_cfg_s x;
    x = '0;
    x.vga_enable = ~s[7];
    x.bus_isolate = s[8];
    x.devsel_ad17 = s[4] & ~(s[6] & ~s[5]);
    x.use_pll = ~s[6] | (~s[5] & ~s[4]);
    case (s[6:4])
      3'h0, 3'h1: x.bus_mode = lv ? bus_strap_pkg::mode_agp4x : bus_strap_pkg::mode_agp1x2x;
      3'h2, 3'h3: x.bus_mode = bus_strap_pkg::mode_agp1x2x;
      3'h4: x.bus_mode = bus_strap_pkg::mode_pci66;
      3'h5: x.bus_mode = bus_strap_pkg::mode_pci33;
      default: x.bus_mode = bus_strap_pkg::mode_agp1x;
    endcase
    x.bus_clock_skew_field = s[1:0];
    x.single_double_clock_skew_field = s[3:2];
    x.rom_kind = s[13] ? bus_strap_pkg::rom_kind_e'(s[13:11]) :
      (s[12] ? bus_strap_pkg::rom_reserved : bus_strap_pkg::rom_none);
    x.identity_from_rom = s[13];
    // identity select only means something when no rom is fitted
    x.chip_identity_select = s[11] & ~s[12] & ~s[13];
    return x;
  endfunction : exp_cfg

  initial begin
    srst = 1'b1;
    cfg_req = 1'b0;
    lowv = 1'b0;
    gpio_in = 14'h0000;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
    for (int i = 0; i < 8; i++) begin
      // skew fields deliberately off 00 on some boards, rom field walks all codes
      g = {i[2:0], 2'b00, i[0], ~i[1], i[2:0], i[1:0], ~i[1:0]};
      @(posedge clk);
      srst <= 1'b1;
      gpio_in <= g;
      lowv <= ~i[0];
      @(posedge clk);
      // first reset edge: pins must already float, before the link reset arrives
      check(32'(gpio_oe), 32'h0, "oe at reset entry");
      check(32'(bus_drive_en), 32'h0, "bus drive at reset entry");
      repeat (11) @(posedge clk);
      check(32'(gpio_oe), 32'h0, "oe in reset");
      check(32'(bus_drive_en), 32'h0, "bus drive in reset");
      srst <= 1'b0;
      @(posedge clk);
      rd_chk(8'h00, 32'(g), "raw straps");
      rd_chk(8'h04, 32'h0, "status before commit");
      repeat (12) @(posedge clk);
      cfg_req <= ~cfg_req;
      for (int n = 0; n < 40 && config_valid !== 1'b1; n++) @(posedge clk);
      e = exp_cfg(g, ~i[0]);
      check(32'(config_valid), 32'h1, "commit");
      if (config_valid !== 1'b1) give_verdict();
      check({16'h0, cfg}, {16'h0, e}, "decode");
      if (g[13:12] == 2'b00) check(32'(cfg[14]), 32'(g[11]), "identity");
      check(32'(bus_drive_en), {31'h0, ~g[8]}, "isolate");
      gpio_in <= ~g;
      cfg_req <= ~cfg_req;
      repeat (30) @(posedge clk);
      check({16'h0, cfg}, {16'h0, e}, "held");
      rd_chk(8'h00, 32'(g), "raw held");
      rd_chk(8'h10, {18'h0, ~g}, "live level");
      rd_chk(8'h04, {15'h0, e, 1'b1}, "status after commit");
      if (i == 0) begin
        wb(1'b1, 8'h0c, 32'hffff_ffff, 4'h3, r);
        rd_chk(8'h0c, 32'h3fff, "oe reg");
        check(32'(gpio_oe), 32'h3fff, "oe pins");
        wb(1'b1, 8'h08, 32'hffff_ffff, 4'h1, r);
        rd_chk(8'h08, 32'h00ff, "out reg");
        check(32'(gpio_out), 32'h00ff, "out pins");
        rd_chk(8'h14, 32'h0, "unmapped");
      end
      $display("test %0d done", i);
    end
    give_verdict();
  end
endmodule : bus_strap_config_latch_test

`default_nettype wire
